// ---- design/io_port_consts.vh ----
// constants for the i/o port mode multiplexer
// assumes a 32-bit apb slave with byte addresses on paddr

`ifndef IO_PORT_CONSTS_VH
`define IO_PORT_CONSTS_VH

// register index inside a port block, paddr[4:2]
`define OFF_DATA_IN 3'h0
`define OFF_DATA_OUT 3'h1
`define OFF_DIR 3'h2
`define OFF_CTRL 3'h3
`define OFF_EN_OUT 3'h4
`define OFF_ICELL 3'h5

// port p block starts at p * 0x20
`define PORT_FLD_LSB 2
`define PORT_SEL_LSB 5
`define ADDR_PERIPH 12'h080
`define PERIPH_EN_BIT 7

`define RST_PORT_REG 8'h00
`define RST_PERIPH 1'b0

// host bus kinds
`define BUS_MUX8 2'h0
`define BUS_PAGE 2'h1
`define BUS_NONMUX 2'h2

`define MASK_FULL 8'hff
`define MASK_PORT_D 8'h07

// scan sharing on the third port
`define SCAN_PIN_MASK 8'h0f
`define SCAN_OUT_BIT 3

`endif

// ---- design/io_port_mode_mux.v ----
// i/o port mode multiplexer: three 8-bit ports and one 3-bit port
// assumes an apb master on pclk and a host bus synchronous to pclk
//
// Overview of operation
// - control bit 0 gives processor i/o
// - output pin driven from data out register
// - data in read returns live pin level
// - ports without control default processor i/o
// - driver enable is direction or oe term
// - tri-state when oe term and direction low
// - address out with ctrl and enable active
// - address out only ports a, b; muxed
// - muxed 8-bit host maps a7-a0 to ports a and b
// - non-muxed host: a7-a0 only port b
// - input cells latch pins on address strobe
// - decode inputs are treated as address inputs
// - data port mode disables port a i/o
// - peripheral mode bit 7 enables port buffer
// - buffer tri-states with no select active
// - third port shared with boundary scan
// - scan enabled by pin, config or input
// - three 8-bit ports, one 3-bit port
// - configuration registers reset to zero
// - control 1 address out, 0 processor i/o
//
// Local design decisions: the placing of the registers and the APB slave port.

`timescale 1ns/1ps
`include "io_port_consts.vh"

module io_port_mode_mux #(
   parameter ADDR_W = 12,
   parameter NPINS = 27
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [15:0] host_addr,
   input wire addr_latch_strobe,
   input wire [1:0] bus_type,
   input wire host_rd,
   input wire host_wr,
   input wire [7:0] host_wdata,
   output wire [7:0] host_rdata,
   output wire host_rdata_oe,
   input wire data_port_mode,
   input wire periph_select_a,
   input wire periph_select_b,
   input wire [NPINS-1:0] pld_assign,
   input wire [NPINS-1:0] pld_oe,
   input wire [NPINS-1:0] pld_out,
   input wire [NPINS-1:0] decode_use,
   output wire [NPINS-1:0] decode_addr,
   input wire scan_select_pin,
   input wire scan_config,
   input wire scan_enable,
   input wire scan_tdo,
   input wire scan_tdo_oe,
   output wire [2:0] scan_in,
   input wire [7:0] port_a_in,
   output wire [7:0] port_a_out,
   output wire [7:0] port_a_oe,
   input wire [7:0] port_b_in,
   output wire [7:0] port_b_out,
   output wire [7:0] port_b_oe,
   input wire [7:0] port_c_in,
   output wire [7:0] port_c_out,
   output wire [7:0] port_c_oe,
   input wire [2:0] port_d_in,
   output wire [2:0] port_d_out,
   output wire [2:0] port_d_oe
);

////////////////////////////////////////////////////////////////////////////////
// decoding

// pins a port really has, so unused bits read as zero
function [7:0] port_mask;
   input [1:0] p;
   begin
      port_mask = (p == 2'd3) ? `MASK_PORT_D : `MASK_FULL;
   end
endfunction

// legal register locations; used for writes and for the error answer
function addr_hit;
   input [ADDR_W-1:0] a;
   reg [2:0] f;
   reg [1:0] p;
   begin
      f = a[`PORT_FLD_LSB+2:`PORT_FLD_LSB];
      p = a[`PORT_SEL_LSB+1:`PORT_SEL_LSB];
      if (a == `ADDR_PERIPH) begin
         addr_hit = 1'b1;
      end else if (a[ADDR_W-1:7] != 0 || a[1:0] != 2'b00) begin
         addr_hit = 1'b0;
      end else if (f == `OFF_CTRL) begin
         addr_hit = (p < 2'd2);
      end else begin
         addr_hit = (f <= `OFF_ICELL);
      end
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [7:0] dout_r [0:3];
reg [7:0] dir_r [0:3];
reg [7:0] ctrl_r [0:1];
reg periph_en;
reg [7:0] icell_r [0:2];
reg [15:0] lat_addr;
integer i;
integer j;

wire [2:0] fld;
wire [1:0] prt;
wire wr_en;
wire hit;

assign fld = paddr[`PORT_FLD_LSB+2:`PORT_FLD_LSB];
assign prt = paddr[`PORT_SEL_LSB+1:`PORT_SEL_LSB];
assign hit = addr_hit(paddr);
assign wr_en = psel & penable & pwrite & hit;

// zero wait states: every access ends in its first access cycle
assign pready = 1'b1;
assign pslverr = psel & penable & ~hit;

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      for (i = 0; i < 4; i = i + 1) begin
         dout_r[i] <= `RST_PORT_REG;
         dir_r[i] <= `RST_PORT_REG;
      end
      ctrl_r[0] <= `RST_PORT_REG;
      ctrl_r[1] <= `RST_PORT_REG;
      periph_en <= `RST_PERIPH;
   end else if (wr_en) begin
      if (paddr == `ADDR_PERIPH) begin
         periph_en <= pwdata[`PERIPH_EN_BIT];
      end else begin
         case (fld)
            `OFF_DATA_OUT: begin
               dout_r[prt] <= pwdata[7:0] & port_mask(prt);
            end
            `OFF_DIR: begin
               dir_r[prt] <= pwdata[7:0] & port_mask(prt);
            end
            `OFF_CTRL: begin
               ctrl_r[prt[0]] <= pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// address latch and input cells

// strobe is a level sampled on pclk; latches follow while it is high
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      lat_addr <= 16'h0000;
      for (j = 0; j < 3; j = j + 1) begin
         icell_r[j] <= 8'h00;
      end
   end else if (addr_latch_strobe) begin
      lat_addr <= host_addr;
      icell_r[0] <= port_a_in;
      icell_r[1] <= port_b_in;
      icell_r[2] <= port_c_in;
   end
end

// decode logic sees latched cells; the small port has no cells
assign decode_addr = decode_use & {port_d_in, icell_r[2], icell_r[1], icell_r[0]};

////////////////////////////////////////////////////////////////////////////////
// latched address routing

wire [7:0] ctrl_w [0:3];
wire [7:0] addr_ok [0:3];
wire [7:0] addr_val [0:3];

assign ctrl_w[0] = ctrl_r[0];
assign ctrl_w[1] = ctrl_r[1];
assign ctrl_w[2] = 8'h00;
assign ctrl_w[3] = 8'h00;

// first port carries the low byte only for a muxed 8-bit host
assign addr_ok[0] = (bus_type == `BUS_MUX8) ? `MASK_FULL : 8'h00;
// second port: low byte, or high byte in page mode; reserved kind gives none
assign addr_ok[1] = (bus_type == `BUS_MUX8 || bus_type == `BUS_PAGE ||
   bus_type == `BUS_NONMUX) ? `MASK_FULL : 8'h00;
assign addr_ok[2] = 8'h00;
assign addr_ok[3] = 8'h00;

assign addr_val[0] = lat_addr[7:0];
assign addr_val[1] = (bus_type == `BUS_PAGE) ? lat_addr[15:8] : lat_addr[7:0];
assign addr_val[2] = 8'h00;
assign addr_val[3] = 8'h00;

////////////////////////////////////////////////////////////////////////////////
// per-port multiplexers

wire [NPINS-1:0] mux_out;
wire [NPINS-1:0] mux_oe;

genvar gp;
generate
   for (gp = 0; gp < 4; gp = gp + 1) begin : g_port
      localparam W = (gp == 3) ? 3 : 8;
      localparam LO = gp * 8;
      port_pin_mux #(
         .W(W),
         .HAS_CTRL((gp < 2) ? 1 : 0)
      ) u_mux (
         .pclk(pclk),
         .presetn(presetn),
         .dir(dir_r[gp][W-1:0]),
         .ctrl(ctrl_w[gp][W-1:0]),
         .dout(dout_r[gp][W-1:0]),
         .pld_assign(pld_assign[LO+W-1:LO]),
         .pld_oe(pld_oe[LO+W-1:LO]),
         .pld_out(pld_out[LO+W-1:LO]),
         .addr_ok(addr_ok[gp][W-1:0]),
         .addr_val(addr_val[gp][W-1:0]),
         .pin_out(mux_out[LO+W-1:LO]),
         .pin_oe(mux_oe[LO+W-1:LO])
      );
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// first port: data port and peripheral buffer

wire buf_mode;
wire buf_sel;

// data port is fixed by configuration and wins over run-time modes
assign buf_mode = data_port_mode | periph_en;
assign buf_sel = data_port_mode | periph_select_a | periph_select_b;

assign port_a_out = buf_mode ? host_wdata : mux_out[7:0];
assign port_a_oe = buf_mode ? {8{buf_sel & host_wr}} : mux_oe[7:0];
assign host_rdata = port_a_in;
assign host_rdata_oe = buf_mode & buf_sel & host_rd;

////////////////////////////////////////////////////////////////////////////////
// second and fourth ports

assign port_b_out = mux_out[15:8];
assign port_b_oe = mux_oe[15:8];
assign port_d_out = mux_out[26:24];
assign port_d_oe = mux_oe[26:24];

////////////////////////////////////////////////////////////////////////////////
// third port: shared with boundary scan

wire scan_on;
wire [7:0] tdo_bit;

// programming never runs in normal operation, so sharing is safe
assign scan_on = scan_select_pin | scan_config | scan_enable;
assign tdo_bit = 8'h01 << `SCAN_OUT_BIT;

assign port_c_out = scan_on ?
   ((mux_out[23:16] & ~`SCAN_PIN_MASK) | (tdo_bit & {8{scan_tdo}})) :
   mux_out[23:16];
assign port_c_oe = scan_on ?
   ((mux_oe[23:16] & ~`SCAN_PIN_MASK) | (tdo_bit & {8{scan_tdo_oe}})) :
   mux_oe[23:16];
assign scan_in = scan_on ? port_c_in[2:0] : 3'h0;

////////////////////////////////////////////////////////////////////////////////
// read path

wire [7:0] pin_in_w [0:3];
wire [7:0] oe_w [0:3];
wire [7:0] icell_w [0:3];

assign pin_in_w[0] = port_a_in;
assign pin_in_w[1] = port_b_in;
assign pin_in_w[2] = port_c_in;
assign pin_in_w[3] = {5'h00, port_d_in};
assign oe_w[0] = port_a_oe;
assign oe_w[1] = port_b_oe;
assign oe_w[2] = port_c_oe;
assign oe_w[3] = {5'h00, port_d_oe};
// the small port has no input cells, so its slot reads as zero
assign icell_w[0] = icell_r[0];
assign icell_w[1] = icell_r[1];
assign icell_w[2] = icell_r[2];
assign icell_w[3] = 8'h00;

// read data is combinational so the zero-wait answer is valid at once
always @* begin
   prdata = 32'h00000000;
   if (psel && !pwrite && hit) begin
      if (paddr == `ADDR_PERIPH) begin
         prdata[`PERIPH_EN_BIT] = periph_en;
      end else begin
         case (fld)
            `OFF_DATA_IN: begin
               prdata[7:0] = pin_in_w[prt];
            end
            `OFF_DATA_OUT: begin
               prdata[7:0] = dout_r[prt];
            end
            `OFF_DIR: begin
               prdata[7:0] = dir_r[prt];
            end
            `OFF_CTRL: begin
               prdata[7:0] = ctrl_r[prt[0]];
            end
            `OFF_EN_OUT: begin
               prdata[7:0] = oe_w[prt];
            end
            `OFF_ICELL: begin
               prdata[7:0] = icell_w[prt];
            end
            default: begin
               prdata = 32'h00000000;
            end
         endcase
      end
   end
end

endmodule // io_port_mode_mux

// ---- design/port_pin_mux.v ----
// per-port output multiplexer and driver enable
// assumes configuration inputs are synchronous to pclk

`timescale 1ns/1ps

module port_pin_mux #(
   parameter W = 8,
   parameter HAS_CTRL = 1
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] dir,
   input wire [W-1:0] ctrl,
   input wire [W-1:0] dout,
   input wire [W-1:0] pld_assign,
   input wire [W-1:0] pld_oe,
   input wire [W-1:0] pld_out,
   input wire [W-1:0] addr_ok,
   input wire [W-1:0] addr_val,
   output reg [W-1:0] pin_out,
   output reg [W-1:0] pin_oe
);

////////////////////////////////////////////////////////////////////////////////

// control bit only counts where the host bus offers an address here
wire [W-1:0] addr_sel;
wire [W-1:0] next_oe;
wire [W-1:0] next_out;

assign addr_sel = (HAS_CTRL != 0) ? (ctrl & addr_ok) : {W{1'b0}};
// oe product term only exists on pins owned by the logic array
assign next_oe = dir | (pld_assign & pld_oe);

genvar gi;
generate
   for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      // array pins take the macrocell, else address, else data out
      assign next_out[gi] = pld_assign[gi] ? pld_out[gi] :
         addr_sel[gi] ? addr_val[gi] :
         dout[gi];
   end
endgenerate

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pin_out <= {W{1'b0}};
      pin_oe <= {W{1'b0}};
   end else begin
      pin_out <= next_out;
      pin_oe <= next_oe;
   end
end

endmodule // port_pin_mux

// ---- test/io_port_monitor_monitor.sv ----
// checker for the i/o port mode multiplexer, bound to its top module
// assumes pin order a 7:0, b 15:8, c 23:16, d 26:24 on the array vectors
`timescale 1ns/1ps
module io_port_monitor #(
   parameter NPINS = 27
) (
   input wire pclk,
   input wire presetn,
   input wire addr_latch_strobe,
   input wire host_rd,
   input wire host_wr,
   input wire [7:0] host_wdata,
   input wire host_rdata_oe,
   input wire data_port_mode,
   input wire periph_select_a,
   input wire periph_select_b,
   input wire [NPINS-1:0] pld_assign,
   input wire [NPINS-1:0] pld_oe,
   input wire [NPINS-1:0] pld_out,
   input wire [NPINS-1:0] decode_use,
   input wire [NPINS-1:0] decode_addr,
   input wire scan_select_pin,
   input wire scan_config,
   input wire scan_enable,
   input wire scan_tdo_oe,
   input wire [2:0] scan_in,
   input wire [7:0] port_a_out,
   input wire [7:0] port_a_oe,
   input wire [7:0] port_b_in,
   input wire [7:0] port_b_oe,
   input wire [7:0] port_c_in,
   input wire [7:0] port_c_out,
   input wire [7:0] port_c_oe,
   input wire [2:0] port_d_in,
   input wire [2:0] port_d_oe
);
   wire scan_on = scan_select_pin | scan_config | scan_enable;
   wire [3:0] arr_oe = pld_assign[23:20] & pld_oe[23:20];
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   AST_ARRAY_OE: assert property (|arr_oe |=> (port_c_oe[7:4] & $past(arr_oe)) == $past(arr_oe))
      else $error("array oe term did not enable the driver");
   AST_ARRAY_OUT: assert property (|pld_assign[23:20] |=>
      ((port_c_out[7:4] ^ $past(pld_out[23:20])) & $past(pld_assign[23:20])) == 4'h0)
      else $error("array-owned pin not driven from the macrocell");
   AST_RESET_TRI: assert property ($rose(presetn) |-> {port_b_oe, port_d_oe} == 11'h000)
      else $error("driver enabled out of reset");
   AST_RDATA_OE: assert property (host_rdata_oe |->
      host_rd && (data_port_mode || periph_select_a || periph_select_b))
      else $error("host data driven without a select");
   AST_DPORT_WR: assert property (data_port_mode && host_wr |->
      port_a_oe == 8'hff && port_a_out == host_wdata)
      else $error("data port write not passed to the pins");
   AST_DPORT_IDLE: assert property (data_port_mode && !host_wr |-> port_a_oe == 8'h00)
      else $error("general i/o still drives in data port mode");
   AST_SCAN_ON: assert property (scan_on |->
      port_c_oe[3:0] == {scan_tdo_oe, 3'h0} && scan_in == port_c_in[2:0])
      else $error("scan pins not taken over");
   AST_SCAN_OFF: assert property (!scan_on |-> scan_in == 3'h0)
      else $error("scan input seen while scan is off");
   AST_ADDR_IN: assert property (addr_latch_strobe |=>
      decode_addr[15:8] == (decode_use[15:8] & $past(port_b_in)))
      else $error("input cell missed the strobe");
   AST_DECODE_D: assert property (decode_addr[26:24] == (decode_use[26:24] & port_d_in))
      else $error("decode input not taken from the pin");
endmodule // io_port_monitor
bind io_port_mode_mux io_port_monitor #(.NPINS(NPINS)) u_mon (.*);

// ---- test/pin_world.sv ----
// far-side pin model: peripherals sharing each port pin
// assumes out and oe come from the port, ext from the bench
`timescale 1ns/1ps
module pin_world #(
   parameter W = 8
) (
   input wire [W-1:0] out,
   input wire [W-1:0] oe,
   input wire [W-1:0] ext,
   output wire [W-1:0] pin
);
   // an undriven pin shows the peripheral level, never the last driven value
   assign pin = (out & oe) | (ext & ~oe);
endmodule // pin_world

// ---- test/testbench.sv ----
// self-checking bench for the i/o port mode multiplexer
// assumes design, pin model and monitor are compiled before it
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdata;
   logic pready, pslverr, host_rdata_oe, addr_latch_strobe = 0, host_rd = 0, host_wr = 0;
   logic data_port_mode = 0, periph_select_a = 0, periph_select_b = 0, scan_tdo = 0;
   logic scan_select_pin = 0, scan_config = 0, scan_enable = 0, scan_tdo_oe = 0;
   logic [15:0] host_addr = 0;
   logic [1:0] bus_type = 0;
   logic [26:0] pld_assign = 0, pld_oe = 0, pld_out = 0, decode_use = 0, decode_addr;
   logic [2:0] scan_in, port_d_in, port_d_out, port_d_oe, ext_d = 3'h5;
   logic [7:0] host_wdata = 0, host_rdata, port_a_in, port_a_out, port_a_oe, ext_a = 8'h96;
   logic [7:0] port_b_in, port_b_out, port_b_oe, port_c_in, port_c_out, port_c_oe;
   logic [7:0] ext_b = 8'h3c, ext_c = 8'h6b;
   int errors = 0, checks = 0;
   io_port_mode_mux dut (.*);
   pin_world pa (.out(port_a_out), .oe(port_a_oe), .ext(ext_a), .pin(port_a_in));
   pin_world pb (.out(port_b_out), .oe(port_b_oe), .ext(ext_b), .pin(port_b_in));
   pin_world pc (.out(port_c_out), .oe(port_c_oe), .ext(ext_c), .pin(port_c_in));
   pin_world #(.W(3)) pd (.out(port_d_out), .oe(port_d_oe), .ext(ext_d), .pin(port_d_in));
   always #25 pclk = ~pclk;
   ////////////////////////////////////////
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // no own limit: only the watchdog may end a wait for the answer
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      `CHK(rdata, e)
   endtask
   // one edge for the mux flops, then sample away from the edge
   task st;
      @(posedge pclk);
      @(negedge pclk);
   endtask
   ////////////////////////////////////////
   task t_reset;
      rd(12'h028, 32'h0);
      rd(12'h00c, 32'h0);
      `CHK({port_a_oe, port_b_oe, port_c_oe, port_d_oe}, 27'h0)
      apb(0, 12'h06c, 32'h0);
      `CHK({rerr, rdata}, 33'h100000000)
   endtask
   task t_cpu_io;
      wr(12'h024, 32'ha5);
      wr(12'h028, 32'h0f);
      st;
      `CHK({port_b_oe, port_b_out}, 16'h0fa5)
      rd(12'h020, 32'h35);
      rd(12'h030, 32'h0f);
      wr(12'h064, 32'hff);
      wr(12'h068, 32'h07);
      rd(12'h064, 32'h07);
      `CHK({port_d_oe, port_d_out}, 6'h3f)
   endtask
   task t_array;
      @(posedge pclk);
      pld_assign <= 27'h0f00000;
      pld_oe <= 27'h0300000;
      pld_out <= 27'h0a00000;
      st;
      `CHK(port_c_oe, 8'h30)
      `CHK(port_c_out[7:4], 4'ha)
      @(posedge pclk);
      pld_oe <= 27'h0;
      st;
      rd(12'h050, 32'h0);
   endtask
   task t_addr;
      @(posedge pclk);
      decode_use <= 27'h7ffffff;
      host_addr <= 16'h5a3c;
      addr_latch_strobe <= 1;
      @(posedge pclk);
      addr_latch_strobe <= 0;
      ext_a <= 8'h11;
      rd(12'h014, 32'h96);
      `CHK(decode_addr[26:24], 3'h7)
      wr(12'h008, 32'hff);
      wr(12'h00c, 32'hff);
      wr(12'h028, 32'hff);
      wr(12'h02c, 32'hff);
      st;
      `CHK({port_a_out, port_b_out}, 16'h3c3c)
      @(posedge pclk);
      bus_type <= 2'h2;
      st;
      `CHK({port_a_out, port_b_out}, 16'h003c)
      @(posedge pclk);
      bus_type <= 2'h1;
      wr(12'h02c, 32'h0f);
      st;
      `CHK(port_b_out, 8'haa)
      @(posedge pclk);
      bus_type <= 2'h3;
      st;
      `CHK(port_b_out, 8'ha5)
      apb(1, 12'h04c, 32'hff);
      `CHK(rerr, 1'b1)
   endtask
   task t_periph;
      wr(12'h080, 32'h80);
      rd(12'h080, 32'h80);
      `CHK(port_a_oe, 8'h00)
      @(posedge pclk);
      periph_select_a <= 1;
      host_wr <= 1;
      host_wdata <= 8'h6e;
      st;
      `CHK({port_a_oe, port_a_out}, 16'hff6e)
      @(posedge pclk);
      periph_select_a <= 0;
      periph_select_b <= 1;
      host_wr <= 0;
      host_rd <= 1;
      st;
      `CHK({host_rdata_oe, port_a_oe, host_rdata}, 17'h10011)
      @(posedge pclk);
      periph_select_b <= 0;
      st;
      `CHK({host_rdata_oe, port_a_oe}, 9'h0)
      wr(12'h080, 32'h0);
      @(posedge pclk);
      host_rd <= 0;
      data_port_mode <= 1;
      st;
      `CHK(port_a_oe, 8'h00)
      @(posedge pclk);
      host_wr <= 1;
      st;
      `CHK({port_a_oe, port_a_out}, 16'hff6e)
      @(posedge pclk);
      host_wr <= 0;
      data_port_mode <= 0;
   endtask
   task t_scan;
      wr(12'h048, 32'h0f);
      for (int i = 0; i < 3; i++) begin
         @(posedge pclk);
         {scan_select_pin, scan_config, scan_enable} <= 3'(3'b100 >> i);
         scan_tdo <= 1;
         scan_tdo_oe <= 1;
         st;
         `CHK({port_c_oe[3:0], port_c_out[3], scan_in}, {5'h11, ext_c[2:0]})
      end
      @(posedge pclk);
      scan_enable <= 0;
      st;
      `CHK({port_c_oe[3:0], scan_in}, 7'h78)
   endtask
   ////////////////////////////////////////
   task give_verdict;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_cpu_io;
      t_array;
      t_addr;
      t_periph;
      t_scan;
      give_verdict;
   end
   // the run needs about 120 cycles; 5000 means a hang
   initial begin
      #250000;
      errors++;
      give_verdict;
   end
endmodule // testbench
